// *** uiet_pkg.sv ***
/*
  uiet_pkg: register map, field positions and reset values for the
  isochronous endpoint transfer block.
  assumes: a 32-bit classic wishbone slave with byte addresses, one word per register.
*/
package uiet_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] UIET_OFF_EP_SELECT  = 8'h00; // endpoint_select_reg
  localparam logic [7:0] UIET_OFF_CONFIG     = 8'h04; // enable, ping-pong, direction
  localparam logic [7:0] UIET_OFF_STATUS     = 8'h08; // endpoint_status_reg
  localparam logic [7:0] UIET_OFF_BYTE_COUNT = 8'h0c; // rx_byte_count_reg
  localparam logic [7:0] UIET_OFF_FIFO       = 8'h10; // endpoint fifo data port
  localparam logic [7:0] UIET_OFF_IRQ_ENABLE = 8'h14; // event enables

  // ---------------------------------------------------------------
  // config fields
  // ---------------------------------------------------------------
  localparam int UIET_CFG_ENABLE = 0;
  localparam int UIET_CFG_PPONG  = 1;
  localparam int UIET_CFG_DIR_IN = 2;
  localparam int UIET_CFG_W      = 3;

  // ---------------------------------------------------------------
  // status and irq enable fields
  // ---------------------------------------------------------------
  localparam int UIET_ST_RX_DONE0 = 0; // rx_done_bank0
  localparam int UIET_ST_RX_DONE1 = 1; // rx_done_bank1
  localparam int UIET_ST_CRC_ERR  = 2; // crc_error_flag
  localparam int UIET_ST_TX_READY = 3; // tx_ready_flag
  localparam int UIET_ST_TX_DONE  = 4; // tx_complete_flag
  localparam int UIET_ST_W        = 5;

  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [3:0]           UIET_RST_EP_SELECT  = 4'h0;
  localparam logic [UIET_CFG_W-1:0] UIET_RST_CONFIG    = 3'h0;
  localparam logic [UIET_ST_W-1:0]  UIET_RST_IRQ_EN    = 5'h00;
  localparam int                   UIET_FIFO_DEPTH    = 64;

endpackage : uiet_pkg

// *** uiet_bank.sv ***
/*
  uiet_bank: one endpoint fifo bank, flip-flop storage with one write
  port and an asynchronous read port, both addressed by index.
  assumes: the owner keeps write and read pointers and never writes past DEPTH.
*/
`timescale 1ns/1ps
module uiet_bank #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock
  input  wire logic          ref_clk_in,
  // write port
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [7:0]    wr_data_in,
  // read port
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [7:0]    rd_data_out
);

  logic [7:0] mem [DEPTH];

  // byte store, no reset needed for data
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // read by index
  assign rd_data_out = mem[rd_addr_in];

endmodule : uiet_bank

// *** uiet_endpoint.sv ***
/*
  uiet_endpoint: isochronous OUT and IN handling of one usb endpoint,
  standard single-bank or two-bank ping-pong, with a wishbone register file.
  assumes: the usb packet engine runs on ref_clk_in and delivers received
  bytes, packet end with crc result, IN requests, byte pulls and packet-sent pulses.
*/
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module uiet_endpoint
  import uiet_pkg::*;
#(
  parameter int         DEPTH = UIET_FIFO_DEPTH,
  parameter logic [3:0] EP_ID = 4'h6
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // usb receive side
  input  wire logic        rx_byte_valid_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_end_in,
  input  wire logic        rx_crc_bad_in,
  // usb transmit side
  input  wire logic        in_req_in,
  input  wire logic        tx_pull_in,
  input  wire logic        tx_sent_in,
  output logic             in_data_out,
  output logic             in_none_out,
  output logic      [7:0]  tx_byte_out,
  output logic      [6:0]  tx_len_out,
  // interrupt
  output logic             ep_irq_out
);

  localparam int              AW   = $clog2(DEPTH);
  localparam int              CW   = $clog2(DEPTH + 1);
  localparam logic [CW-1:0]   FULL = CW'(DEPTH);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0]            ep_sel;
  logic [UIET_CFG_W-1:0] cfg;
  logic [UIET_ST_W-1:0]  irq_en;
  logic                  crc_err;
  logic                  rx_fill, rx_read, tx_fill, tx_send, tx_busy;
  logic [1:0]            rx_done, tx_rdy, tx_cmp;
  logic [CW-1:0]         cnt [2];
  logic [CW-1:0]         rdp [2];
  logic [7:0]            rdat [2];
  logic [1:0]            set_rx, clr_rx, set_trdy, tx_fin, wr_en, pop;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire en       = cfg[UIET_CFG_ENABLE];
  wire pp       = cfg[UIET_CFG_PPONG];
  wire dir_in   = cfg[UIET_CFG_DIR_IN];
  wire sel_ok   = (ep_sel == EP_ID);
  wire wb_take  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wr       = wb_take & wb_we_in & wb_sel_in[0];
  wire rd       = wb_take & ~wb_we_in;
  wire a_sel    = (wb_adr_in == UIET_OFF_EP_SELECT);
  wire a_cfg    = (wb_adr_in == UIET_OFF_CONFIG);
  wire a_stat   = (wb_adr_in == UIET_OFF_STATUS);
  wire a_cnt    = (wb_adr_in == UIET_OFF_BYTE_COUNT);
  wire a_fifo   = (wb_adr_in == UIET_OFF_FIFO);
  wire a_ien    = (wb_adr_in == UIET_OFF_IRQ_ENABLE);
  // endpoint accesses only count when this endpoint is selected
  wire cfg_wr   = wr & a_cfg & sel_ok;
  wire stat_wr  = wr & a_stat & sel_ok;
  wire ien_wr   = wr & a_ien & sel_ok;
  wire fifo_wr  = wr & a_fifo & sel_ok & dir_in;
  wire fifo_rd  = rd & a_fifo & sel_ok & ~dir_in;
  wire fw_bank  = dir_in ? tx_fill : rx_read;
  wire clr_crc  = stat_wr & wb_dat_in[UIET_ST_CRC_ERR];
  wire clr_txc  = stat_wr & wb_dat_in[UIET_ST_TX_DONE];

  // ---------------------------------------------------------------
  // usb side decode
  // ---------------------------------------------------------------
  // host bytes are taken only for an enabled OUT endpoint with a free bank
  wire rx_ok    = en & ~dir_in & ~rx_done[rx_fill];
  wire store    = rx_byte_valid_in & rx_ok & (cnt[rx_fill] < FULL);
  wire rx_fin   = rx_end_in & rx_ok;
  wire in_hit   = in_req_in & en & dir_in & ~tx_busy;
  wire tx_end   = tx_sent_in & tx_busy;

  // IN answer: data only when the send bank is marked ready
  assign in_data_out = in_hit & tx_rdy[tx_send];
  assign in_none_out = in_hit & ~tx_rdy[tx_send];
  assign tx_byte_out = rdat[tx_send];
  assign tx_len_out  = 7'(cnt[tx_send]);

  // ---------------------------------------------------------------
  // per-bank flags, counts and storage
  // ---------------------------------------------------------------
  for (genvar b = 0; b < 2; b++) begin : g_bank
    localparam logic BK = 1'(b);
    logic [CW-1:0] cnt_q, rdp_q;
    logic          rxd_q, trdy_q, txc_q;
    wire           flush = cfg_wr | clr_rx[b] | tx_fin[b];

    // bank 1 only takes part in ping-pong mode
    assign set_rx[b]   = rx_fin & (rx_fill == BK);
    assign clr_rx[b]   = stat_wr & wb_dat_in[UIET_ST_RX_DONE0 + b] & rxd_q;
    assign set_trdy[b] = stat_wr & wb_dat_in[UIET_ST_TX_READY] & dir_in
                         & (tx_fill == BK) & ~trdy_q;
    assign tx_fin[b]   = tx_end & (tx_send == BK);
    assign wr_en[b]    = (store & (rx_fill == BK))
                         | (fifo_wr & (tx_fill == BK) & (cnt_q < FULL));
    assign pop[b]      = (fifo_rd & (rx_read == BK) & (rdp_q < cnt_q))
                         | (tx_pull_in & tx_busy & (tx_send == BK) & (rdp_q < cnt_q));
    assign cnt[b]      = cnt_q;
    assign rdp[b]      = rdp_q;
    assign rx_done[b]  = rxd_q;
    assign tx_rdy[b]   = trdy_q;
    assign tx_cmp[b]   = txc_q;

    // byte count and read pointer, emptied when the bank is freed
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        cnt_q <= '0;
        rdp_q <= '0;
      end else if (flush) begin
        cnt_q <= '0;
        rdp_q <= '0;
      end else begin
        cnt_q <= cnt_q + CW'(wr_en[b]);
        rdp_q <= rdp_q + CW'(pop[b]);
      end
    end

    // event flags, a set in the clearing cycle wins, except for tx ready, where tx_fin clears it
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        rxd_q  <= 1'b0;
        trdy_q <= 1'b0;
        txc_q  <= 1'b0;
      end else if (cfg_wr) begin
        rxd_q  <= 1'b0;
        trdy_q <= 1'b0;
        txc_q  <= 1'b0;
      end else begin
        rxd_q  <= (rxd_q & ~clr_rx[b]) | set_rx[b];
        trdy_q <= (trdy_q | set_trdy[b]) & ~tx_fin[b];
        txc_q  <= (txc_q & ~clr_txc) | tx_fin[b];
      end
    end

    uiet_bank #(
      .DEPTH (DEPTH),
      .AW    (AW)
    ) u_bank (
      .ref_clk_in  (ref_clk_in),
      .wr_en_in    (wr_en[b]),
      .wr_addr_in  (AW'(cnt_q)),
      .wr_data_in  (dir_in ? wb_dat_in[7:0] : rx_byte_in),
      .rd_addr_in  (AW'(rdp_q)),
      .rd_data_out (rdat[b])
    );
  end

  // ---------------------------------------------------------------
  // bank pointers
  // ---------------------------------------------------------------
  // all pointers start at bank 0 after reset or a config write
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_fill <= 1'b0;
      rx_read <= 1'b0;
      tx_fill <= 1'b0;
      tx_send <= 1'b0;
    end else if (cfg_wr) begin
      rx_fill <= 1'b0;
      rx_read <= 1'b0;
      tx_fill <= 1'b0;
      tx_send <= 1'b0;
    end else begin
      rx_fill <= rx_fill ^ (pp & rx_fin);
      rx_read <= rx_read ^ (pp & clr_rx[rx_read]);
      tx_fill <= tx_fill ^ (pp & |set_trdy);
      tx_send <= tx_send ^ (pp & tx_end);
    end
  end

  // ---------------------------------------------------------------
  // transmit busy and crc flag
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_busy <= 1'b0;
      crc_err <= 1'b0;
    end else begin
      tx_busy <= ~cfg_wr & (in_data_out | (tx_busy & ~tx_sent_in));
      // each stored packet overwrites the crc result
      crc_err <= rx_fin ? rx_crc_bad_in : (crc_err & ~clr_crc & ~cfg_wr);
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ep_sel <= UIET_RST_EP_SELECT;
      cfg    <= UIET_RST_CONFIG;
      irq_en <= UIET_RST_IRQ_EN;
    end else begin
      if (wr & a_sel) begin
        ep_sel <= wb_dat_in[3:0];
      end
      if (cfg_wr) begin
        cfg <= wb_dat_in[UIET_CFG_W-1:0];
      end
      if (ien_wr) begin
        irq_en <= wb_dat_in[UIET_ST_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux and bus answer
  // ---------------------------------------------------------------
  wire [UIET_ST_W-1:0] status = {|tx_cmp, tx_rdy[tx_fill], crc_err, rx_done};
  wire [31:0] rd_mux =
      a_sel             ? {28'h0, ep_sel} :
      (a_cfg & sel_ok)  ? {29'h0, cfg} :
      (a_stat & sel_ok) ? {27'h0, status} :
      (a_cnt & sel_ok)  ? {{(32 - CW){1'b0}}, cnt[fw_bank]} :
      (fifo_rd)         ? {24'h0, rdat[rx_read]} :
      (a_ien & sel_ok)  ? {27'h0, irq_en} : 32'h0;

  // one wait state, ack for every address including unmapped ones
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_take;
      if (rd) begin
        wb_dat_out <= rd_mux;
      end
    end
  end

  // interrupt from the rx done, crc and tx complete flags and their enables; tx ready never interrupts
  assign ep_irq_out = |(irq_en & {|tx_cmp, 1'b0, crc_err, rx_done});

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_end_bank0;
    rx_end_in && en && !dir_in && !rx_fill && !rx_done[0] && !cfg_wr;
  endsequence

  sequence s_bank0_done_irq;
    rx_done[0] && (!irq_en[UIET_ST_RX_DONE0] || ep_irq_out);
  endsequence

  chk_rx_done_bank0 : assert property (s_end_bank0 |=> s_bank0_done_irq)
    else $error("bank 0 done flag or interrupt missing after packet end");

  chk_count_byte : assert property (
    rx_byte_valid_in && en && !dir_in && !rx_fill && !rx_done[0] && cnt[0] < FULL
    && !cfg_wr |=> cnt[0] == $past(cnt[0]) + 1)
    else $error("byte count did not advance on a stored byte");

  chk_crc_follow : assert property (
    s_end_bank0 |=> crc_err == $past(rx_crc_bad_in))
    else $error("crc flag not refreshed by new packet");

  chk_rx_discard : assert property (
    rx_done[rx_fill] && !cfg_wr && !clr_rx[rx_fill] |=> cnt[$past(rx_fill)] ==
    $past(cnt[rx_fill]))
    else $error("data stored into a bank still marked done");

  chk_overflow_drop : assert property (
    s_end_bank0 ##0 (cnt[0] == FULL) |=> rx_done[0] && cnt[0] == FULL)
    else $error("full packet not kept as valid");

  chk_rx_swap : assert property (
    pp && clr_rx[rx_read] && !cfg_wr |=> rx_read != $past(rx_read))
    else $error("read bank did not swap on done clear");

  // the bank just filled is marked done and the other one takes the next packet
  chk_rx_alternate : assert property (
    pp && rx_fin && !cfg_wr |=> rx_fill != $past(rx_fill)
    && rx_done[$past(rx_fill)])
    else $error("receive banks not used alternately");

  chk_in_nothing : assert property (
    in_req_in && en && dir_in && !tx_busy && !tx_rdy[tx_send] |->
    in_none_out && !in_data_out)
    else $error("data offered without tx ready");

  chk_tx_complete : assert property (
    tx_end && !cfg_wr |=> tx_cmp[$past(tx_send)] && !tx_rdy[$past(tx_send)]
    && !tx_busy)
    else $error("tx complete not set after packet sent");

  chk_tx_switch : assert property (
    pp && |set_trdy && !cfg_wr |=> tx_fill != $past(tx_fill))
    else $error("fill bank did not switch on tx ready");

  chk_reconf_zero : assert property (
    cfg_wr |=> !rx_fill && !rx_read && !tx_fill && !tx_send)
    else $error("bank pointers not at bank 0 after reconfiguration");

  sequence s_enabled_event;
    (rx_done[1] && irq_en[UIET_ST_RX_DONE1]) || (|tx_cmp && irq_en[UIET_ST_TX_DONE]);
  endsequence

  chk_irq_gate : assert property (irq_en == '0 |-> !ep_irq_out)
    else $error("interrupt raised with every event masked");

  chk_irq_raise : assert property (s_enabled_event |-> ep_irq_out)
    else $error("enabled event flag raised no interrupt");

endmodule : uiet_endpoint

// *** uiet_usb_host_model.sv ***
/*
  uiet_usb_host_model: host side of the endpoint, as seen through the usb packet engine.
  assumes: shares ref_clk_in with the endpoint; the bench calls its tasks.
*/
`timescale 1ns/1ps
module uiet_usb_host_model (
  // clock
  input  wire logic       ref_clk_in,
  // toward the endpoint
  output logic            rx_byte_valid_out,
  output logic [7:0]      rx_byte_out,
  output logic            rx_end_out,
  output logic            rx_crc_bad_out,
  output logic            in_req_out,
  output logic            tx_pull_out,
  output logic            tx_sent_out,
  // endpoint answers
  input  wire logic       in_data_in,
  input  wire logic       in_none_in,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic [6:0] tx_len_in
);
  logic [7:0] got [$];

  // idle engine at time zero
  initial begin
    rx_byte_valid_out = 1'b0;
    rx_byte_out       = 8'h00;
    rx_end_out        = 1'b0;
    rx_crc_bad_out    = 1'b0;
    in_req_out        = 1'b0;
    tx_pull_out       = 1'b0;
    tx_sent_out       = 1'b0;
  end

  // one out packet, bytes seed upward, then the end strobe with crc result;
  // no data toggle travels with an isochronous packet
  task automatic send_out(input int n, input logic [7:0] seed, input logic bad);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_in);
      rx_byte_valid_out <= 1'b1;
      rx_byte_out       <= seed + 8'(i);
    end
    @(posedge ref_clk_in);
    rx_byte_valid_out <= 1'b0;
    rx_byte_out       <= ~rx_byte_out; // idle line never shows the stale byte
    rx_end_out        <= 1'b1;
    rx_crc_bad_out    <= bad;
    @(posedge ref_clk_in);
    rx_end_out        <= 1'b0;
    rx_crc_bad_out    <= ~bad;
  endtask : send_out

  // one in token; pulls every byte offered, then reports the packet sent
  task automatic in_token(output logic data, output logic none);
    int len;
    got.delete();
    @(posedge ref_clk_in);
    in_req_out <= 1'b1;
    // answer and length taken at the edge that takes the token
    @(posedge ref_clk_in);
    data       = in_data_in;
    none       = in_none_in;
    len        = int'(tx_len_in);
    in_req_out <= 1'b0;
    if (data === 1'b1) begin
      for (int i = 0; i < len; i++) begin
        @(posedge ref_clk_in);
        tx_pull_out <= 1'b1;
        // byte taken at the edge that takes the pull
        @(posedge ref_clk_in);
        got.push_back(tx_byte_in);
        tx_pull_out <= 1'b0;
      end
      @(posedge ref_clk_in);
      tx_sent_out <= 1'b1;
      @(posedge ref_clk_in);
      tx_sent_out <= 1'b0;
    end
  endtask : in_token
endmodule : uiet_usb_host_model

// *** uiet_endpoint_tb_top.sv ***
/*
  uiet_endpoint_tb_top: self-checking bench for the isochronous endpoint.
  assumes: uiet_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
module uiet_endpoint_tb_top;
  import uiet_pkg::*;
  typedef struct {int len; logic bad; logic [31:0] cnt; logic [31:0] st;} uiet_row_t;
  logic        ref_clk_in, rst_b_in, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr, tx_byte, rx_byte;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [6:0]  tx_len;
  logic        rx_valid, rx_end, rx_bad, in_req, tx_pull, tx_sent;
  logic        in_data, in_none, irq, d, n;
  int          n_mismatch, compares, cyc_cnt;
  uiet_row_t   rows [4];

  uiet_endpoint dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .rx_byte_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_end_in(rx_end),
    .rx_crc_bad_in(rx_bad), .in_req_in(in_req), .tx_pull_in(tx_pull), .tx_sent_in(tx_sent),
    .in_data_out(in_data), .in_none_out(in_none), .tx_byte_out(tx_byte),
    .tx_len_out(tx_len), .ep_irq_out(irq));
  uiet_usb_host_model model (.ref_clk_in(ref_clk_in), .rx_byte_valid_out(rx_valid),
    .rx_byte_out(rx_byte), .rx_end_out(rx_end), .rx_crc_bad_out(rx_bad),
    .in_req_out(in_req), .tx_pull_out(tx_pull), .tx_sent_out(tx_sent),
    .in_data_in(in_data), .in_none_in(in_none), .tx_byte_in(tx_byte), .tx_len_in(tx_len));

  // clock and hang guard
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // compare, bus and report tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge ref_clk_in);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= 4'hf;
    wb_wdat <= dat;
    do @(posedge ref_clk_in); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat);
  endtask : wr
  task automatic rd(input logic [7:0] adr);
    wb_xfer(1'b0, adr, 32'h0);
  endtask : rd
  task automatic drain(input logic [7:0] seed, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      rd(UIET_OFF_FIFO);
      chk(q, {24'h0, seed + 8'(i)});
    end
  endtask : drain
  task automatic fill(input logic [7:0] seed, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      wr(UIET_OFF_FIFO, {24'h0, seed + 8'(i)});
    end
  endtask : fill
  task automatic sent_chk(input logic [7:0] seed, input int cnt);
    chk(model.got.size(), cnt);
    for (int i = 0; i < cnt; i++) begin
      chk({24'h0, model.got[i]}, {24'h0, seed + 8'(i)});
    end
  endtask : sent_chk
  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rows = '{'{0, 1'b0, 32'h0, 32'h1}, '{5, 1'b1, 32'h5, 32'h5},
             '{64, 1'b0, 32'h40, 32'h1}, '{70, 1'b0, 32'h40, 32'h1}};
    rst_b_in   = 1'b0;
    wb_cyc     = 1'b0;
    wb_stb     = 1'b0;
    wb_we      = 1'b0;
    wb_adr     = 8'h00;
    wb_sel     = 4'h0;
    wb_wdat    = 32'h0;
    n_mismatch = 0;
    compares   = 0;
    cyc_cnt    = 0;
    repeat (3) @(posedge ref_clk_in);
    chk({in_data, in_none, wb_ack, irq, tx_len}, 32'h0);
    rst_b_in <= 1'b1;
    wr(UIET_OFF_CONFIG, 32'h1);
    rd(UIET_OFF_EP_SELECT);
    chk(q, {28'h0, UIET_RST_EP_SELECT});
    rd(8'h20);
    chk(q, 32'h0);
    wr(UIET_OFF_EP_SELECT, 32'h6);
    rd(UIET_OFF_CONFIG);
    chk(q, {29'h0, UIET_RST_CONFIG});
    rd(UIET_OFF_IRQ_ENABLE);
    chk(q, {27'h0, UIET_RST_IRQ_EN});
    $display("test reset done");
    // standard out packets from the table
    wr(UIET_OFF_CONFIG, 32'h1);
    wr(UIET_OFF_IRQ_ENABLE, 32'h1f);
    foreach (rows[r]) begin
      model.send_out(rows[r].len, 8'h10, rows[r].bad);
      rd(UIET_OFF_STATUS);
      chk(q, rows[r].st);
      chk(irq, 1'b1);
      rd(UIET_OFF_BYTE_COUNT);
      chk(q, rows[r].cnt);
      drain(8'h10, int'(rows[r].cnt));
      wr(UIET_OFF_STATUS, 32'h1);
      rd(UIET_OFF_STATUS);
      chk(q, rows[r].st & 32'h4);
      chk(irq, rows[r].bad);
      $display("test row %0d done", r);
    end
    // second packet while done is set, then clear in mid-packet
    model.send_out(3, 8'h40, 1'b0);
    model.send_out(5, 8'h50, 1'b0);
    rd(UIET_OFF_BYTE_COUNT);
    chk(q, 32'h3);
    drain(8'h40, 3);
    fork
      model.send_out(20, 8'h60, 1'b0);
      wr(UIET_OFF_STATUS, 32'h1);
    join
    rd(UIET_OFF_BYTE_COUNT);
    chk(q, 32'h13);
    drain(8'h61, 19);
    wr(UIET_OFF_STATUS, 32'h1);
    $display("test drop and mid-packet clear done");
    // masked interrupt
    wr(UIET_OFF_IRQ_ENABLE, 32'h0);
    model.send_out(1, 8'h33, 1'b0);
    chk(irq, 1'b0);
    wr(UIET_OFF_IRQ_ENABLE, 32'h1);
    chk(irq, 1'b1);
    wr(UIET_OFF_STATUS, 32'h1);
    $display("test irq mask done");
    // ping-pong receive
    wr(UIET_OFF_CONFIG, 32'h3);
    wr(UIET_OFF_IRQ_ENABLE, 32'h1f);
    model.send_out(3, 8'h70, 1'b0);
    model.send_out(4, 8'h80, 1'b0);
    rd(UIET_OFF_STATUS);
    chk(q, 32'h3);
    rd(UIET_OFF_BYTE_COUNT);
    chk(q, 32'h3);
    drain(8'h70, 3);
    wr(UIET_OFF_STATUS, 32'h1);
    rd(UIET_OFF_BYTE_COUNT);
    chk(q, 32'h4);
    chk(irq, 1'b1);
    drain(8'h80, 4);
    wr(UIET_OFF_STATUS, 32'h2);
    rd(UIET_OFF_STATUS);
    chk(q, 32'h0);
    $display("test ping-pong receive done");
    // standard in transfer
    wr(UIET_OFF_CONFIG, 32'h5);
    model.in_token(d, n);
    chk({d, n}, 32'h1);
    fill(8'ha0, 3);
    wr(UIET_OFF_STATUS, 32'h8);
    model.in_token(d, n);
    chk({d, n}, 32'h2);
    sent_chk(8'ha0, 3);
    rd(UIET_OFF_STATUS);
    chk(q, 32'h10);
    chk(irq, 1'b1);
    wr(UIET_OFF_STATUS, 32'h10);
    $display("test standard in done");
    // ping-pong transmit
    wr(UIET_OFF_CONFIG, 32'h7);
    fill(8'hb0, 2);
    wr(UIET_OFF_STATUS, 32'h8);
    fill(8'hc0, 2);
    wr(UIET_OFF_STATUS, 32'h8);
    model.in_token(d, n);
    sent_chk(8'hb0, 2);
    model.in_token(d, n);
    sent_chk(8'hc0, 2);
    rd(UIET_OFF_STATUS);
    chk(q, 32'h10);
    model.in_token(d, n);
    chk({d, n}, 32'h1);
    $display("test ping-pong transmit done");
    test_done();
  end
endmodule : uiet_endpoint_tb_top
